//--- common/asdw_regs.vh
// Register offsets, field positions and sizes of the sample writer
`ifndef ASDW_REGS_VH
`define ASDW_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ASDW_ADDR_W 12
`define ASDW_OFS_TALLY 12'h130
`define ASDW_OFS_FILL 12'h134
`define ASDW_OFS_BASE 12'h140
`define ASDW_OFS_LEN 12'h144
`define ASDW_OFS_NEXT 12'h148
`define ASDW_OFS_STAT 12'h14c

// ****************************************
// Field layout and reset values
// ****************************************
`define ASDW_TALLY_W 28
`define ASDW_LEN_W 28
`define ASDW_REG_RESET 32'h00000000
`define ASDW_TERM_ERR 2
`define ASDW_TERM_BLOCK 1
`define ASDW_TERM_BUFEND 0
`define ASDW_SAMPLE_W 16
`define ASDW_SAMPLE_BYTES 28'h0000002
`define ASDW_FIFO_DEPTH 8
`define ASDW_FIFO_AW 3
`define ASDW_BE_LOW 4'h3
`define ASDW_BE_HIGH 4'hc
`define ASDW_BE_ALL 4'hf

`endif

//--- hw/asdw_fifo.v
// Sample FIFO with valid/ready on both sides and a fill count
`timescale 1ns/10ps
module asdw_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire srst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  reg room;
  wire push;
  wire pop;
  wire [AW:0] next_count;

  assign push = inValid & room;
  assign pop = outReady & (count != {(AW+1){1'b0}});
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign inReady = room;
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  assign level = count;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      room <= 1'b1;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      count <= next_count;
      room <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule

//--- hw/asdw_writer.v
// Converter sample writer: tally, fill level, buffer engine, status record
//
// Notes on behaviour
// (R1) 28-bit conversion tally; normal mode zeroes it on each start request.
// (R2) Frame mode zeroes tally on frame trigger, not when frame error.
// (R3) Fill level reported in bytes, two bytes per stored sample.
// (R4) Samples are written from the programmed 32-bit buffer base onward.
// (R5) Base is captured when the length is written; later changes ignored.
// (R6) Writing the 28-bit byte length starts a buffer transfer.
// (R7) Start only while idle flag is 1; software checks it first.
// (R8) Next host write address is readable to gauge remaining space.
// (R9) With status enabled, a status word goes to the status address.
// (R10) Status word is little-endian, like the registers.
// (R11) Bit 30: stopped early by conversion fault or queue overflow.
// (R12) Bit 29: configured block or frame fully written.
// (R13) Bit 28: buffer full; a new buffer is needed to continue.
// (R14) Bits 27:0 hold bytes transferred; bit 31 reserved zero.
// (R15) Writing the length clears the termination reason flags.
// (R16) Master or target abort sets transfer error and stops engine.
// (R17) Disabling completes the active write, then resets the engine.
// (R18) Pointer advances per write; writing stops at base plus length.
// (R19) All registers read zero after reset.
`timescale 1ns/10ps
`include "asdw_regs.vh"
module asdw_writer (
  input wire clk_sys,
  input wire srst,
  input wire regWr,
  input wire [`ASDW_ADDR_W-1:0] regAddr,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata,
  input wire transferEngineEnable,
  input wire statusReportEnable,
  input wire frameMode,
  input wire conversionStartRequest,
  input wire frameTrigger,
  input wire frameOverrunFault,
  input wire conversionPerformed,
  input wire blockComplete,
  input wire conversionOverlapFault,
  input wire sampleQueueOverflow,
  input wire sampleValid,
  input wire [`ASDW_SAMPLE_W-1:0] sampleData,
  output wire sampleReady,
  output reg engineIdle,
  output reg engineBusy,
  output reg transferError,
  output reg [2:0] terminationFlags,
  output reg mstReq,
  output reg [31:0] mstAddr,
  output reg [31:0] mstData,
  output reg [3:0] mstBe,
  input wire mstAck,
  input wire mstMasterAbort,
  input wire mstTargetAbort
);
  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RUN = 3'd1;
  localparam [2:0] ST_WRITE = 3'd2;
  localparam [2:0] ST_STATUS = 3'd3;
  localparam [2:0] ST_ERROR = 3'd4;

  reg [2:0] state;
  reg [`ASDW_TALLY_W-1:0] tally;
  reg [31:0] fillBytes;
  reg [31:0] bufBase;
  reg [`ASDW_LEN_W-1:0] bufLen;
  reg [31:0] activeBase;
  reg [`ASDW_LEN_W-1:0] activeLen;
  reg [31:0] nextPtr;
  reg [`ASDW_LEN_W-1:0] bytesDone;
  reg [31:0] statAddr;
  reg errSeen;
  reg blockSeen;
  reg [31:0] next_rdata;

  wire fifoValid;
  wire [`ASDW_SAMPLE_W-1:0] fifoData;
  wire [`ASDW_FIFO_AW:0] fifoLevel;
  wire fifoPop;
  wire lenWrite;
  wire startOk;
  wire atEnd;
  wire abort;
  wire [2:0] termNow;

  // ****************************************
  // Sample FIFO
  // ****************************************
  asdw_fifo #(
    .WIDTH(`ASDW_SAMPLE_W),
    .DEPTH(`ASDW_FIFO_DEPTH),
    .AW(`ASDW_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(sampleData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData),
    .level(fifoLevel)
  );

  assign lenWrite = regWr & (regAddr == `ASDW_OFS_LEN);
  assign startOk = lenWrite & engineIdle; // [R7]
  assign atEnd = (bytesDone >= activeLen); // [R18]
  assign abort = mstMasterAbort | mstTargetAbort;
  assign fifoPop = (state == ST_RUN) & transferEngineEnable & ~atEnd &
                   fifoValid;
  assign termNow = {errSeen & ~fifoValid, blockSeen & ~fifoValid, atEnd};

  // ****************************************
  // Tally and fill level
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      tally <= {`ASDW_TALLY_W{1'b0}}; // [R19]
      fillBytes <= `ASDW_REG_RESET;
    end else begin
      if (!frameMode && conversionStartRequest) begin
        tally <= {`ASDW_TALLY_W{1'b0}}; // [R1]
      end else if (frameMode && frameTrigger && !frameOverrunFault) begin
        tally <= {`ASDW_TALLY_W{1'b0}}; // [R2]
      end else if (conversionPerformed) begin
        tally <= tally + {{(`ASDW_TALLY_W-1){1'b0}}, 1'b1}; // [R1]
      end
      fillBytes <= {{(31-`ASDW_FIFO_AW-1){1'b0}}, fifoLevel, 1'b0}; // [R3]
    end
  end

  // ****************************************
  // Software-written registers
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      bufBase <= `ASDW_REG_RESET;
      bufLen <= {`ASDW_LEN_W{1'b0}};
      statAddr <= `ASDW_REG_RESET;
    end else if (regWr) begin
      case (regAddr)
        `ASDW_OFS_BASE: begin
          bufBase <= regWdata;
        end
        `ASDW_OFS_LEN: begin
          bufLen <= regWdata[`ASDW_LEN_W-1:0];
        end
        `ASDW_OFS_STAT: begin
          statAddr <= regWdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Register read mux
  // ****************************************
  always @* begin
    next_rdata = 32'h00000000;
    case (regAddr)
      `ASDW_OFS_TALLY: next_rdata = {4'h0, tally};
      `ASDW_OFS_FILL: next_rdata = fillBytes;
      `ASDW_OFS_BASE: next_rdata = bufBase;
      `ASDW_OFS_LEN: next_rdata = {4'h0, bufLen};
      `ASDW_OFS_NEXT: next_rdata = nextPtr; // [R8]
      `ASDW_OFS_STAT: next_rdata = statAddr;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      regRdata <= `ASDW_REG_RESET;
    end else begin
      regRdata <= next_rdata;
    end
  end

  // ****************************************
  // Early-stop causes, set wins over clear
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      errSeen <= 1'b0;
      blockSeen <= 1'b0;
    end else begin
      errSeen <= (errSeen & ~startOk) | conversionOverlapFault |
                 sampleQueueOverflow; // [R11]
      blockSeen <= (blockSeen & ~startOk) | blockComplete; // [R12]
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      activeBase <= `ASDW_REG_RESET;
      activeLen <= {`ASDW_LEN_W{1'b0}};
      nextPtr <= `ASDW_REG_RESET;
      bytesDone <= {`ASDW_LEN_W{1'b0}};
      terminationFlags <= 3'b000;
      transferError <= 1'b0;
      mstReq <= 1'b0;
      mstAddr <= `ASDW_REG_RESET;
      mstData <= `ASDW_REG_RESET;
      mstBe <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startOk) begin // [R6]
            activeBase <= bufBase; // [R5]
            activeLen <= regWdata[`ASDW_LEN_W-1:0];
            nextPtr <= bufBase; // [R4]
            bytesDone <= {`ASDW_LEN_W{1'b0}};
            terminationFlags <= 3'b000; // [R15]
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!transferEngineEnable) begin
            state <= ST_IDLE; // [R17]
          end else if (fifoPop) begin
            mstReq <= 1'b1;
            mstAddr <= nextPtr;
            if (nextPtr[1]) begin
              mstData <= {fifoData, 16'h0000};
              mstBe <= `ASDW_BE_HIGH;
            end else begin
              mstData <= {16'h0000, fifoData};
              mstBe <= `ASDW_BE_LOW;
            end
            state <= ST_WRITE;
          end else if (termNow != 3'b000) begin
            terminationFlags <= termNow; // [R11] [R12] [R13]
            if (statusReportEnable) begin
              mstReq <= 1'b1; // [R9]
              mstAddr <= statAddr;
              mstData <= {1'b0, termNow, bytesDone}; // [R10] [R14]
              mstBe <= `ASDW_BE_ALL;
              state <= ST_STATUS;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (abort) begin
            mstReq <= 1'b0;
            transferError <= 1'b1; // [R16]
            state <= ST_ERROR;
          end else if (mstAck) begin
            mstReq <= 1'b0;
            nextPtr <= nextPtr + {30'h0, 2'h2}; // [R18]
            bytesDone <= bytesDone + `ASDW_SAMPLE_BYTES;
            state <= ST_RUN; // [R17]
          end
        end
        ST_STATUS: begin
          if (abort) begin
            mstReq <= 1'b0;
            transferError <= 1'b1; // [R16]
            state <= ST_ERROR;
          end else if (mstAck) begin
            mstReq <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_ERROR: begin
          if (!transferEngineEnable) begin
            transferError <= 1'b0; // [R17]
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Engine flags
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      engineIdle <= 1'b0;
      engineBusy <= 1'b0;
    end else begin
      engineIdle <= transferEngineEnable & (state == ST_IDLE) & ~startOk;
      engineBusy <= (state == ST_RUN) | (state == ST_WRITE) |
                    (state == ST_STATUS) | startOk;
    end
  end
endmodule

//--- sim/asdw_host_mem.sv
// Host memory answering the bus-master writes
`timescale 1ns/10ps
module asdw_host_mem (
  input wire clk_sys,
  input wire mstReq,
  input wire [31:0] mstAddr,
  input wire [31:0] mstData,
  input wire [3:0] mstBe,
  input wire [1:0] latency,
  input wire [1:0] abortNext,
  output logic mstAck,
  output logic mstMasterAbort,
  output logic mstTargetAbort
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] word;
  logic [1:0] waitCnt;
  initial begin
    {mstAck, mstMasterAbort, mstTargetAbort, waitCnt} = 5'h00;
  end
  always @(posedge clk_sys) begin
    {mstAck, mstMasterAbort, mstTargetAbort} <= 3'h0;
    if (mstReq && !mstAck && !mstMasterAbort && !mstTargetAbort) begin
      if (waitCnt < latency) begin
        waitCnt <= waitCnt + 2'h1;
      end else begin
        waitCnt <= 2'h0;
        if (abortNext != 2'h0) begin
          {mstMasterAbort, mstTargetAbort} <= abortNext;
        end else begin
          word = mem.exists({mstAddr[31:2], 2'h0}) ?
            mem[{mstAddr[31:2], 2'h0}] : 32'h0;
          // Little-endian lanes merged by byte enable
          for (int i = 0; i < 4; i++) begin
            if (mstBe[i]) word[8*i+:8] = mstData[8*i+:8];
          end
          mem[{mstAddr[31:2], 2'h0}] = word;
          mstAck <= 1'b1;
        end
      end
    end
  end
endmodule

//--- sim/asdw_props.sv
// Port assertions for the converter sample writer
`timescale 1ns/10ps
module asdw_props (
  input wire clk_sys,
  input wire srst,
  input wire regWr,
  input wire [11:0] regAddr,
  input wire [31:0] regRdata,
  input wire transferEngineEnable,
  input wire engineIdle,
  input wire engineBusy,
  input wire transferError,
  input wire [2:0] terminationFlags,
  input wire mstReq,
  input wire [31:0] mstAddr,
  input wire [31:0] mstData,
  input wire [3:0] mstBe,
  input wire mstAck,
  input wire mstMasterAbort,
  input wire mstTargetAbort
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_abort;
    mstReq && transferEngineEnable && (mstMasterAbort || mstTargetAbort);
  endsequence
  sequence s_len_wr;
    regWr && regAddr == 12'h144;
  endsequence
  sequence s_wait;
    mstReq && !mstAck && !mstMasterAbort && !mstTargetAbort;
  endsequence
  a_abort_error: assert property (s_abort |=> transferError)
    else $error("abort did not raise transfer error");
  a_abort_stops: assert property (s_abort |=> !mstReq ##1 !engineBusy)
    else $error("engine kept running after abort");
  a_req_holds: assert property (s_wait |=> mstReq && $stable(mstAddr)
    && $stable(mstData) && $stable(mstBe))
    else $error("bus write changed before answer");
  a_ack_drops: assert property (mstReq && mstAck |=> !mstReq)
    else $error("request stayed up after ack");
  a_start_busy: assert property (s_len_wr and engineIdle |=>
    engineBusy && !engineIdle && terminationFlags == 3'h0)
    else $error("length write did not start buffer");
  a_busy_nostart: assert property (s_len_wr and !engineIdle &&
    !engineBusy |=> !engineBusy)
    else $error("buffer started while not idle");
  a_lane_select: assert property (mstReq && mstBe != 4'hf |->
    mstBe == (mstAddr[1] ? 4'hc : 4'h3))
    else $error("sample on wrong byte lanes");
  a_status_resv: assert property (mstReq && mstBe == 4'hf |-> !mstData[31])
    else $error("status reserved bit set");
  a_reset_zero: assert property (disable iff (1'b0) $past(srst) |->
    regRdata == 32'h0 && !mstReq && !engineBusy)
    else $error("outputs not cleared by reset");
endmodule
bind asdw_writer asdw_props chk_u (.*);

//--- sim/asdw_writer_tb.sv
// Self-checking testbench of the converter sample writer
`timescale 1ns/10ps
module asdw_writer_tb;
  logic clk_sys, srst, regWr, transferEngineEnable, statusReportEnable;
  logic frameMode, conversionStartRequest, frameTrigger, frameOverrunFault;
  logic conversionPerformed, blockComplete, conversionOverlapFault;
  logic sampleQueueOverflow, sampleValid, sampleReady;
  logic engineIdle, engineBusy, transferError, mstReq;
  logic mstAck, mstMasterAbort, mstTargetAbort;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, mstAddr, mstData, b, s;
  logic [15:0] sampleData;
  logic [15:0] smp [8];
  logic [2:0] terminationFlags;
  logic [3:0] mstBe;
  logic [1:0] latency, abortNext;
  int mismatches, num_checks;
  asdw_writer dut_u (.*);
  asdw_host_mem host_u (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task regW(logic [11:0] a, logic [31:0] d);
    {regWr, regAddr, regWdata} = {1'b1, a, d};
    tick(1);
    regWr = 1'b0;
    tick(1);
  endtask
  task rd(logic [11:0] a, logic [31:0] exp, string what);
    regAddr = a;
    tick(1);
    chk(what, regRdata, exp);
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    tick(1);
    p = 1'b0;
    tick(1);
  endtask
  task push(logic [15:0] d);
    {sampleValid, sampleData} = {1'b1, d};
    tick(1);
    sampleValid = 1'b0;
    tick(1);
  endtask
  task waitSig(bit err);
    for (int i = 0; i < 800 && (err ? transferError : engineIdle) !== 1'b1;
      i++) tick(1);
    chk("wait flag", err ? transferError : engineIdle, 1);
  endtask
  initial begin
    {srst, regWr, transferEngineEnable, frameMode, conversionStartRequest,
      frameTrigger, frameOverrunFault, conversionPerformed, blockComplete,
      conversionOverlapFault, sampleQueueOverflow, sampleValid} = 12'h800;
    {regAddr, regWdata, sampleData, latency, abortNext} = 64'h0;
    statusReportEnable = 1'b1;
    b = $urandom(98);
    tick(10);
    srst = 1'b0;
    for (int a = 'h130; a <= 'h150; a += 4) rd(12'(a), 0, "reset value");
    repeat (5) pulse(conversionPerformed);
    rd(12'h130, 5, "tally");
    pulse(conversionStartRequest);
    rd(12'h130, 0, "tally start");
    frameMode = 1'b1;
    repeat (3) pulse(conversionPerformed);
    frameOverrunFault = 1'b1;
    pulse(frameTrigger);
    frameOverrunFault = 1'b0;
    rd(12'h130, 3, "tally frame fault");
    pulse(frameTrigger);
    rd(12'h130, 0, "tally frame");
    frameMode = 1'b0;
    for (int i = 0; i < 8; i++) begin
      smp[i] = $urandom;
      push(smp[i]);
    end
    tick(2);
    chk("queue full", sampleReady, 0);
    rd(12'h134, 16, "fill bytes");
    b = $urandom & 32'hffff_fff0;
    s = b + 32'h1000;
    regW(12'h140, b);
    regW(12'h14c, s);
    transferEngineEnable = 1'b1;
    latency = $urandom % 4;
    waitSig(0);
    regW(12'h144, 16);
    regW(12'h140, ~b);
    waitSig(0);
    for (int k = 0; k < 4; k++)
      chk("host word", host_u.mem[b+4*k], {smp[2*k+1], smp[2*k]});
    chk("status full", host_u.mem[s], 32'h1000_0010);
    chk("flags full", terminationFlags, 1);
    rd(12'h148, b + 16, "next pointer");
    regW(12'h140, b + 32'h100);
    regW(12'h144, 32'h100);
    push(smp[7]);
    push(smp[0]);
    pulse(conversionOverlapFault);
    pulse(blockComplete);
    waitSig(0);
    chk("host word 2", host_u.mem[b+32'h100], {smp[0], smp[7]});
    chk("status early", host_u.mem[s], 32'h6000_0004);
    chk("flags early", terminationFlags, 6);
    statusReportEnable = 1'b0;
    regW(12'h140, b + 32'h200);
    regW(12'h144, 4);
    push(smp[1]);
    push(smp[2]);
    waitSig(0);
    chk("host word 3", host_u.mem[b+32'h200], {smp[2], smp[1]});
    chk("no status", host_u.mem[s], 32'h6000_0004);
    chk("flags no status", terminationFlags, 1);
    statusReportEnable = 1'b1;
    abortNext = 2'h1 + $urandom % 2;
    regW(12'h144, 16);
    chk("flags cleared", terminationFlags, 0);
    push(smp[3]);
    waitSig(1);
    tick(1);
    chk("busy after abort", engineBusy, 0);
    regW(12'h144, 16);
    chk("no start in error", engineBusy, 0);
    transferEngineEnable = 1'b0;
    tick(2);
    chk("error cleared", transferError, 0);
    end_sim;
  end
endmodule
